//--- nand_ops_pkg.sv
// Constants shared by the serial NAND command engine and its helpers.
// Assumes a single core clock of 50 MHz; all times are turned into cycles here.
package nand_ops_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Self-timed operation durations (plain defaults)
    localparam int ERASE_TIME_US = 2000;
    localparam int PROG_TIME_US = 250;
    localparam int PAGE_LOAD_TIME_US = 25;
    localparam int ERASE_CYCLES = (ERASE_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int PROG_CYCLES = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int PAGE_LOAD_CYCLES = (PAGE_LOAD_TIME_US * 1000) / CLK_PERIOD_NS;

    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR_A = 8'h0f;
    localparam logic [7:0] OP_RDSR_B = 8'h05;
    localparam logic [7:0] OP_FAIL_PAGE = 8'ha9;
    localparam logic [7:0] OP_ERASE = 8'hd8;
    localparam logic [7:0] OP_LOAD = 8'h02;
    localparam logic [7:0] OP_RLOAD = 8'h84;
    localparam logic [7:0] OP_QLOAD = 8'h32;
    localparam logic [7:0] OP_QRLOAD = 8'h34;
    localparam logic [7:0] OP_PEXEC = 8'h10;
    localparam logic [7:0] OP_PREAD = 8'h13;

    localparam int PAGE_BYTES = 2112;
    localparam int MAIN_BYTES = 2048;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int SECTORS = 4;
    localparam int SECTOR_BYTES = 512;
    localparam int ECC_SPARE_OFS = 8;
    localparam logic [11:0] ECC_POS_FIRST = 12'(MAIN_BYTES + ECC_SPARE_OFS);
    localparam logic [11:0] ECC_POS_LAST = 12'(MAIN_BYTES + ECC_SPARE_OFS + SECTORS - 1);
    localparam logic [11:0] PAGE_LAST = 12'(PAGE_BYTES - 1);
    localparam logic [11:0] PAGE_END = 12'(PAGE_BYTES);

    // Serial frame bit counts
    localparam logic [5:0] OP_BITS = 6'd8;
    localparam logic [5:0] STATUS_HDR_BITS = 6'd16;
    localparam logic [5:0] LOAD_HDR_BITS = 6'd24;
    localparam logic [5:0] ARRAY_CMD_BITS = 6'd32;
    localparam logic [5:0] HDR_CNT_MAX = 6'h3f;
    localparam logic [2:0] SINGLE_LAST_BIT = 3'd7;
    localparam logic [2:0] QUAD_LAST_NIB = 3'd1;

    // Status byte layout returned by status reads
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_ECC0_BIT = 4;
    localparam int SR_ECC1_BIT = 5;
    localparam logic [1:0] ECC_CLEAN = 2'b00;
    localparam logic [1:0] ECC_UNCORR = 2'b10;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage

//--- pin_sync.sv
// Two-stage synchroniser for asynchronous pins, plus a delayed copy for edges.
// Assumes the pins change slower than the core clock by a wide margin.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] q_prev
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            q <= '0;
            q_prev <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
            q_prev <= q;
        end
    end
endmodule // pin_sync
`default_nettype wire

//--- ecc_sector_parity.sv
// Per-sector byte-wise XOR check data over the main area of one page.
// Bytes arrive in index order; clr restarts a page.
`timescale 1ns/100ps
`default_nettype none
module ecc_sector_parity
    import nand_ops_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] data,
    input wire logic [11:0] idx,
    input wire logic [1:0] sel,
    output logic [7:0] par
);
    logic [7:0] par_q [SECTORS];

    genvar s;
    generate
        for (s = 0; s < SECTORS; s++)
        begin : g_sec
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    par_q[s] <= '0;
                else if (clr)
                    par_q[s] <= '0;
                else if (en && idx < 12'(MAIN_BYTES) && int'(idx) / SECTOR_BYTES == s)
                    par_q[s] <= par_q[s] ^ data;
            end
        end
    endgenerate

    assign par = par_q[sel];
endmodule // ecc_sector_parity
`default_nettype wire

//--- serial_nand_array_ops.sv
// Command engine of a serial NAND: loads, program, erase, page read, check data.
// Assumes SPI pins are asynchronous to MCLK and SCLK is at most MCLK/8;
// configuration inputs come from logic on MCLK.
`timescale 1ns/100ps
`default_nettype none
module serial_nand_array_ops
    import nand_ops_pkg::*;
#(
    parameter int PAGES = 128,
    parameter int ERASE_CYC = nand_ops_pkg::ERASE_CYCLES,
    parameter int PROG_CYC = nand_ops_pkg::PROG_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic CS_B,
    input wire logic SCLK,
    input wire logic [3:0] IO_IN,
    input wire logic ECC_EN,
    input wire logic BUF_MODE,
    input wire logic WP_EN,
    input wire logic PROTECT_TOP_BOTTOM,
    input wire logic BLOCK_PROTECT_2,
    input wire logic BLOCK_PROTECT_1,
    input wire logic BLOCK_PROTECT_0,
    output logic SDO,
    output logic SDO_OE,
    output logic BUSY,
    output logic WRITE_ENABLE_LATCH,
    output logic [1:0] ECC_STATUS,
    output logic [15:0] FAIL_PAGE,
    output logic CONT_READ_MODE
);
    import nand_ops_pkg::*;

    localparam int ARR_W = $clog2(PAGES * PAGE_BYTES);
    localparam int PG_W = $clog2(PAGES);
    localparam int BLOCKS = PAGES / PAGES_PER_BLOCK;

    typedef enum {L_IDLE, L_OPC, L_HDR, L_LOAD, L_OUT, L_SKIP} link_e;
    typedef enum {E_IDLE, E_ERASE, E_PROG, E_READ} eng_e;

    // Pin sampling; chip select goes through inverted so reset equals its idle level
    logic cs_act_s, cs_act_p, sclk_s, sclk_p;
    logic [3:0] io_s, io_p;
    pin_sync #(.W(6)) u_sync (
        .clk(MCLK),
        .rst_b(RST_B),
        .d({~CS_B, SCLK, IO_IN}),
        .q({cs_act_s, sclk_s, io_s}),
        .q_prev({cs_act_p, sclk_p, io_p})
    );
    wire cs_s = ~cs_act_s;
    wire cs_p = ~cs_act_p;
    wire sclk_rise = sclk_s & ~sclk_p & ~cs_s;
    wire sclk_fall = ~sclk_s & sclk_p & ~cs_s;
    wire cs_fall = ~cs_s & cs_p;
    wire cs_rise = cs_s & ~cs_p;
    wire sdi = io_s[0];

    link_e ln_q;
    eng_e eng_q;
    logic [5:0] bit_cnt_q;
    logic [7:0] opc_q;
    logic [23:0] hdr_q;
    logic [11:0] col_q;
    logic [7:0] dat_sr_q;
    logic [2:0] dat_cnt_q;
    logic quad_q;
    logic [15:0] out_sr_q;
    logic busy_q, wel_q, cont_q;
    logic [1:0] ecc_st_q;
    logic [15:0] fail_pg_q;
    logic [7:0] buf_mem [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] buf_val_q;
    logic [7:0] arr_mem [PAGES * PAGE_BYTES];
    logic [PAGES-1:0] pg_val_q;
    logic [11:0] idx_q;
    logic [31:0] timer_q;
    logic [15:0] eng_pg_q;
    logic mism_q;

    // Header decode
    wire [7:0] opc_d = {opc_q[6:0], sdi};
    wire [5:0] bit_inc = (bit_cnt_q == HDR_CNT_MAX) ? bit_cnt_q : bit_cnt_q + 6'd1;
    wire [23:0] hdr_d = {hdr_q[22:0], sdi};
    wire is_status = (opc_q == OP_RDSR_A) || (opc_q == OP_RDSR_B);
    wire is_load = (opc_q == OP_LOAD) || (opc_q == OP_RLOAD)
        || (opc_q == OP_QLOAD) || (opc_q == OP_QRLOAD);
    wire d_status = (opc_d == OP_RDSR_A) || (opc_d == OP_RDSR_B);
    wire d_quad = (opc_d == OP_QLOAD) || (opc_d == OP_QRLOAD);
    wire d_load = (opc_d == OP_LOAD) || (opc_d == OP_RLOAD) || d_quad;
    wire d_plain = (opc_d == OP_LOAD) || (opc_d == OP_QLOAD);
    wire opc_done = (ln_q == L_OPC) && sclk_rise && (bit_inc == OP_BITS);
    wire d_reject = busy_q ? !d_status : ((d_quad && WP_EN) || (d_load && !wel_q));

    // Load data byte assembly, four bits per edge for quad
    wire [7:0] byte_d = quad_q ? {dat_sr_q[3:0], io_s} : {dat_sr_q[6:0], sdi};
    wire byte_last = quad_q ? (dat_cnt_q == QUAD_LAST_NIB) : (dat_cnt_q == SINGLE_LAST_BIT);
    wire ld_wr = (ln_q == L_LOAD) && sclk_rise && byte_last && (col_q < PAGE_END);

    // Protected region: count of blocks doubles per step of the protect code
    function automatic logic is_protected(input logic [15:0] pg);
        int blk;
        int cnt;
        logic [2:0] bp;
        blk = int'(pg[PG_W-1:0]) / PAGES_PER_BLOCK;
        bp = {BLOCK_PROTECT_2, BLOCK_PROTECT_1, BLOCK_PROTECT_0};
        cnt = (bp == 3'd0) ? 0 : (1 << (int'(bp) - 1));
        if (bp == 3'd0)
            return 1'b0;
        if (PROTECT_TOP_BOTTOM)
            return blk < cnt;
        return blk >= BLOCKS - cnt;
    endfunction

    // Array command closes only when chip select rises right after bit 32
    wire arr_close = cs_rise && (ln_q == L_HDR) && (bit_cnt_q == ARRAY_CMD_BITS);
    wire [15:0] cmd_pg = hdr_q[15:0];
    wire start_erase = arr_close && opc_q == OP_ERASE && wel_q && !is_protected(cmd_pg);
    wire start_prog = arr_close && opc_q == OP_PEXEC && wel_q && !is_protected(cmd_pg);
    wire start_read = arr_close && opc_q == OP_PREAD;
    wire eng_start = start_erase || start_prog || start_read;

    logic [7:0] status_byte;
    always_comb
    begin
        status_byte = '0;
        status_byte[SR_BUSY_BIT] = busy_q;
        status_byte[SR_WEL_BIT] = wel_q;
        status_byte[SR_ECC0_BIT] = ecc_st_q[0];
        status_byte[SR_ECC1_BIT] = ecc_st_q[1];
    end

    // Serial link sequencing
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ln_q <= L_IDLE;
            bit_cnt_q <= '0;
            opc_q <= '0;
            hdr_q <= '0;
            quad_q <= 1'b0;
        end
        else if (cs_rise || cs_s)
            ln_q <= L_IDLE;
        else if (cs_fall)
        begin
            ln_q <= L_OPC;
            bit_cnt_q <= '0;
        end
        else if (sclk_rise)
        begin
            case (ln_q)
                L_OPC:
                begin
                    opc_q <= opc_d;
                    bit_cnt_q <= bit_inc;
                    quad_q <= d_quad;
                    if (opc_done)
                        ln_q <= d_reject ? L_SKIP : L_HDR;
                end
                L_HDR:
                begin
                    hdr_q <= hdr_d;
                    bit_cnt_q <= bit_inc;
                    if ((is_status || opc_q == OP_FAIL_PAGE) && bit_inc == STATUS_HDR_BITS)
                        ln_q <= L_OUT;
                    else if (is_load && bit_inc == LOAD_HDR_BITS)
                        ln_q <= L_LOAD;
                end
                default:
                    ln_q <= ln_q;
            endcase
        end
    end

    // Load column and byte assembly
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            col_q <= '0;
            dat_sr_q <= '0;
            dat_cnt_q <= '0;
        end
        else if (sclk_rise && ln_q == L_HDR && bit_inc == LOAD_HDR_BITS)
        begin
            col_q <= hdr_d[11:0];
            dat_cnt_q <= '0;
        end
        else if (sclk_rise && ln_q == L_LOAD)
        begin
            dat_sr_q <= byte_d;
            dat_cnt_q <= byte_last ? 3'd0 : dat_cnt_q + 3'd1;
            if (byte_last && col_q < PAGE_END)
                col_q <= col_q + 12'd1;
        end
    end

    // Serial output, MSB first on falling edges
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            out_sr_q <= '0;
            SDO <= 1'b0;
            SDO_OE <= 1'b0;
        end
        else
        begin
            SDO_OE <= (ln_q == L_OUT) && !cs_s;
            if (sclk_rise && ln_q == L_HDR && bit_inc == STATUS_HDR_BITS)
                out_sr_q <= is_status ? {status_byte, status_byte} : fail_pg_q;
            else if (sclk_fall && ln_q == L_OUT)
            begin
                SDO <= out_sr_q[15];
                // Rotate so the byte or page repeats for as long as clocks come
                out_sr_q <= {out_sr_q[14:0], out_sr_q[15]};
            end
        end
    end

    // Write enable latch
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            wel_q <= 1'b0;
        else if (cs_rise && ln_q == L_HDR && bit_cnt_q == OP_BITS && opc_q == OP_WREN)
            wel_q <= 1'b1;
        else if (cs_rise && ln_q == L_HDR && bit_cnt_q == OP_BITS && opc_q == OP_WRDI)
            wel_q <= 1'b0;
        else if (eng_q != E_READ && eng_q != E_IDLE && idx_q == PAGE_END && timer_q == '0)
            wel_q <= 1'b0;
    end

    // Engine: timer plus one byte per cycle of copying
    wire copy_done = (idx_q == PAGE_END);
    wire eng_done = (eng_q != E_IDLE) && copy_done && (timer_q == '0);
    wire [ARR_W-1:0] arr_idx = ARR_W'(int'(eng_pg_q[PG_W-1:0]) * PAGE_BYTES + int'(idx_q));
    wire pg_ok = pg_val_q[eng_pg_q[PG_W-1:0]];
    wire [7:0] arr_rd = pg_ok ? arr_mem[arr_idx] : ERASED_BYTE;
    wire [7:0] buf_rd = buf_val_q[idx_q] ? buf_mem[idx_q] : ERASED_BYTE;
    wire par_pos = ECC_EN && idx_q >= ECC_POS_FIRST && idx_q <= ECC_POS_LAST;
    wire [1:0] par_sel = 2'(idx_q - ECC_POS_FIRST);
    wire copying = (eng_q == E_PROG || eng_q == E_READ) && !copy_done;
    wire [7:0] par;
    wire [7:0] feed = (eng_q == E_PROG) ? buf_rd : arr_rd;

    ecc_sector_parity u_ecc (
        .clk(MCLK),
        .rst_b(RST_B),
        .clr(eng_start),
        .en(copying),
        .data(feed),
        .idx(idx_q),
        .sel(par_sel),
        .par(par)
    );

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            eng_q <= E_IDLE;
            busy_q <= 1'b0;
            idx_q <= '0;
            timer_q <= '0;
            eng_pg_q <= '0;
        end
        else if (eng_start)
        begin
            eng_q <= start_erase ? E_ERASE : (start_prog ? E_PROG : E_READ);
            busy_q <= 1'b1;
            idx_q <= start_erase ? PAGE_END : '0;
            timer_q <= start_erase ? 32'(ERASE_CYC)
                : (start_prog ? 32'(PROG_CYC) : 32'(PAGE_LOAD_CYCLES));
            eng_pg_q <= cmd_pg;
        end
        else if (eng_done)
        begin
            eng_q <= E_IDLE;
            busy_q <= 1'b0;
        end
        else if (eng_q != E_IDLE)
        begin
            if (timer_q != '0)
                timer_q <= timer_q - 32'd1;
            if (!copy_done)
                idx_q <= idx_q + 12'd1;
        end
    end

    // Array store; programming only clears bits of a written page
    always_ff @(posedge MCLK)
    begin
        if (eng_q == E_PROG && !copy_done)
            arr_mem[arr_idx] <= (pg_ok ? arr_mem[arr_idx] : ERASED_BYTE)
                & (par_pos ? par : buf_rd);
    end

    genvar p;
    generate
        for (p = 0; p < PAGES; p++)
        begin : g_page
            always_ff @(posedge MCLK or negedge RST_B)
            begin
                if (!RST_B)
                    pg_val_q[p] <= 1'b0;
                else if (start_erase && p / PAGES_PER_BLOCK == int'(cmd_pg[PG_W-1:0]) / PAGES_PER_BLOCK)
                    pg_val_q[p] <= 1'b0;
                else if (eng_q == E_PROG && eng_done && p == int'(eng_pg_q[PG_W-1:0]))
                    pg_val_q[p] <= 1'b1;
            end
        end
    endgenerate

    // Page buffer and its written-byte map
    always_ff @(posedge MCLK)
    begin
        if (eng_q == E_READ && !copy_done)
            buf_mem[idx_q] <= arr_rd;
        else if (ld_wr)
            buf_mem[col_q] <= byte_d;
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            buf_val_q <= '0;
        else if (opc_done && !d_reject && d_plain)
            buf_val_q <= '0;
        else if (eng_q == E_READ && !copy_done)
            buf_val_q[idx_q] <= 1'b1;
        else if (ld_wr)
            buf_val_q[col_q] <= 1'b1;
    end

    // Check-data verification and status
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            mism_q <= 1'b0;
            ecc_st_q <= ECC_CLEAN;
            fail_pg_q <= '0;
            cont_q <= 1'b0;
        end
        else if (start_read)
            mism_q <= 1'b0;
        else if (eng_q == E_READ && !copy_done && par_pos && pg_ok && arr_rd != par)
            mism_q <= 1'b1;
        else if (eng_q == E_READ && eng_done)
        begin
            ecc_st_q <= (ECC_EN && mism_q) ? ECC_UNCORR : ECC_CLEAN;
            if (ECC_EN && mism_q)
                fail_pg_q <= eng_pg_q;
            cont_q <= !BUF_MODE;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            BUSY <= 1'b0;
            WRITE_ENABLE_LATCH <= 1'b0;
            ECC_STATUS <= ECC_CLEAN;
            FAIL_PAGE <= '0;
            CONT_READ_MODE <= 1'b0;
        end
        else
        begin
            BUSY <= busy_q;
            WRITE_ENABLE_LATCH <= wel_q;
            ECC_STATUS <= ecc_st_q;
            FAIL_PAGE <= fail_pg_q;
            CONT_READ_MODE <= cont_q;
        end
    end

    sequence s_erase_cmd;
        arr_close && opc_q == OP_ERASE;
    endsequence
    sequence s_op_end;
        eng_done && eng_q != E_READ;
    endsequence

    erase_needs_wel_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        s_erase_cmd and (!wel_q) |=> eng_q == E_IDLE)
        else $error("erase started without write enable");
    erase_clears_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        start_erase |=> !pg_val_q[eng_pg_q[PG_W-1:0]] && busy_q)
        else $error("erase did not clear block pages");
    op_end_wel_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        s_op_end |=> !wel_q && !busy_q ##1 !BUSY && !WRITE_ENABLE_LATCH)
        else $error("latch or busy not cleared at end");
    busy_held_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        eng_q != E_IDLE && !eng_done |=> busy_q)
        else $error("busy dropped during operation");
    quad_reject_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        opc_done && d_quad && WP_EN |=> ln_q == L_SKIP)
        else $error("quad command taken while protected");
    protect_refuse_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        arr_close && opc_q != OP_PREAD && is_protected(cmd_pg) |=> eng_q == E_IDLE)
        else $error("protected region modified");
    buf_bound_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        ld_wr |-> col_q <= PAGE_LAST)
        else $error("load wrote past buffer");
    ecc_report_a: assert property (@(posedge MCLK) disable iff (!RST_B)
        eng_q == E_READ && eng_done && ECC_EN && mism_q |=> ecc_st_q == ECC_UNCORR ##1
        ECC_STATUS == ECC_UNCORR)
        else $error("uncorrectable page not reported");
endmodule // serial_nand_array_ops
`default_nettype wire

//--- spi_host_model.sv
// Host model: drives chip select, serial clock and IO lines of the engine.
// Assumes clk is MCLK at 50 MHz; SCLK runs at 8 clk cycles a bit, idle low.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    input wire logic clk,
    input wire logic sdo,
    output logic cs_b,
    output logic sclk,
    output logic [3:0] io
);
    initial
    begin
        cs_b = 1'b1;
        sclk = 1'b0;
        io = 4'h0;
    end
    // Low 5, high 3; SDO settles 3-4 clk after a fall, so it is read at the rise
    task automatic bit_xfer(input logic [3:0] v, output logic r);
        io <= v;
        repeat (5) @(posedge clk);
        r = sdo;
        sclk <= 1'b1;
        repeat (3) @(posedge clk);
        sclk <= 1'b0;
    endtask
    // Single-line frame, MSB first; CS_B rises right after the last bit
    task automatic frame(input logic [63:0] d, input int n, output logic [63:0] r);
        logic b;
        r = '0;
        @(posedge clk);
        cs_b <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            bit_xfer({3'h0, d[i]}, b);
            r = {r[62:0], b};
        end
        repeat (4) @(posedge clk);
        cs_b <= 1'b1;
        io <= ~io;
        repeat (6) @(posedge clk);
    endtask
endmodule // spi_host_model
`default_nettype wire

//--- serial_nand_array_ops_tb.sv
// Bench for the serial NAND command engine, driven through the host model.
// Assumes short erase and program times set by parameter.
`timescale 1ns/100ps
`default_nettype none
module serial_nand_array_ops_tb;
    logic mclk, rst_b, cs_b, sclk, sdo, sdo_oe, busy, write_enable_latch, cont;
    logic ecc_en, buf_mode, wp_en, tb_bit, bp2, bp1, bp0;
    logic [3:0] io;
    logic [1:0] ecc_st;
    logic [15:0] fail_pg;
    logic [63:0] r;
    int n_fail = 0;
    int n_compared = 0;
    spi_host_model host (.clk(mclk), .sdo(sdo), .cs_b(cs_b), .sclk(sclk), .io(io));
    serial_nand_array_ops #(.PAGES(128), .ERASE_CYC(50), .PROG_CYC(50)) DUT (
        .MCLK(mclk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk), .IO_IN(io),
        .ECC_EN(ecc_en), .BUF_MODE(buf_mode), .WP_EN(wp_en),
        .PROTECT_TOP_BOTTOM(tb_bit), .BLOCK_PROTECT_2(bp2), .BLOCK_PROTECT_1(bp1),
        .BLOCK_PROTECT_0(bp0), .SDO(sdo), .SDO_OE(sdo_oe), .BUSY(busy),
        .WRITE_ENABLE_LATCH(write_enable_latch), .ECC_STATUS(ecc_st), .FAIL_PAGE(fail_pg),
        .CONT_READ_MODE(cont));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Bounded wait for the engine to go idle
    task automatic wait_idle();
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 5000)
        begin
            @(posedge mclk);
            i++;
        end
        if (i == 5000)
        begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic t_latch();
        host.frame({8'hd8, 24'h0}, 32, r);
        check("busy no latch", busy, 1'b0);
        host.frame(64'h06, 8, r);
        check("latch set", write_enable_latch, 1'b1);
        $display("t_latch done");
    endtask
    task automatic t_erase();
        host.frame({8'hd8, 24'h0}, 32, r);
        check("erase busy", busy, 1'b1);
        wait_idle();
        check("erase latch", write_enable_latch, 1'b0);
        $display("t_erase done");
    endtask
    task automatic t_protect();
        @(posedge mclk);
        bp0 <= 1'b1;
        host.frame(64'h06, 8, r);
        // Code 1, top: last block of two, so page 64 is refused
        host.frame({8'hd8, 8'h00, 16'h0040}, 32, r);
        check("protected busy", busy, 1'b0);
        check("protected latch", write_enable_latch, 1'b1);
        @(posedge mclk);
        bp0 <= 1'b0;
        $display("t_protect done");
    endtask
    task automatic t_prog_read();
        host.frame({8'h02, 16'h0000, 40'h0123456789}, 64, r);
        host.frame({8'h10, 8'h00, 16'h0001}, 32, r);
        check("program busy", busy, 1'b1);
        wait_idle();
        check("program latch", write_enable_latch, 1'b0);
        @(posedge mclk);
        buf_mode <= 1'b0;
        host.frame({8'h13, 8'h00, 16'h0001}, 32, r);
        check("read busy", busy, 1'b1);
        // Copy lasts over 2112 cycles, longer than one status read
        host.frame({8'h05, 8'ha0, 8'h00}, 24, r);
        check("status in busy", r[7:0], 8'h01);
        wait_idle();
        check("ecc clean", ecc_st, 2'b00);
        check("cont mode", cont, 1'b1);
        host.frame({8'ha9, 24'h0}, 32, r);
        check("fail page out", r[15:0], 16'h0000);
        check("fail page port", fail_pg, 16'h0000);
        $display("t_prog_read done");
    endtask
    // Page 2 programmed with correction off keeps FFh where check data belongs
    task automatic t_ecc_fail();
        host.frame(64'h06, 8, r);
        host.frame({8'h02, 16'h0000, 40'h0123456789}, 64, r);
        @(posedge mclk);
        ecc_en <= 1'b0;
        host.frame({8'h10, 8'h00, 16'h0002}, 32, r);
        wait_idle();
        @(posedge mclk);
        ecc_en <= 1'b1;
        host.frame({8'h13, 8'h00, 16'h0002}, 32, r);
        wait_idle();
        check("ecc uncorrectable", ecc_st, 2'b10);
        check("fail page port 2", fail_pg, 16'h0002);
        host.frame({8'ha9, 24'h0}, 32, r);
        check("fail page out 2", r[15:0], 16'h0002);
        $display("t_ecc_fail done");
    endtask
    initial
    begin
        rst_b = 1'b0;
        ecc_en = 1'b1;
        buf_mode = 1'b1;
        wp_en = 1'b0;
        tb_bit = 1'b0;
        bp2 = 1'b0;
        bp1 = 1'b0;
        bp0 = 1'b0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        t_latch();
        t_erase();
        t_protect();
        t_prog_read();
        t_ecc_fail();
        wrap_up();
    end
endmodule // serial_nand_array_ops_tb
`default_nettype wire
